// ### tutr_regs.v
// translation unit tuning register bank on a classic wishbone slave
//
// Local design decision: register access over Wishbone.
`include "tutr_defs.vh"
module tutr_regs #(
   parameter SLOT_W            = 12,
   parameter SHARED_SLOT_PARAM = 12'h100
) (
   // =====================================
   // clock and reset
   input  wire              clk_i,
   input  wire              rst_i,
   // =====================================
   // wishbone slave
   input  wire              cyc_i,
   input  wire              stb_i,
   input  wire              we_i,
   input  wire [19:0]       adr_i,
   input  wire [3:0]        sel_i,
   input  wire [31:0]       dat_i,
   input  wire              nonsecure_i,
   output reg  [31:0]       dat_o,
   output reg               ack_o,
   // =====================================
   // system state
   input  wire              sec_override_i,
   input  wire              translation_enable_ns_i,
   input  wire              translation_enable_s_i,
   // =====================================
   // walk master port transaction
   input  wire [1:0]        txn_type_i,
   input  wire [1:0]        node_priority_level_i,
   output wire [3:0]        walk_master_port_qos_o,
   // =====================================
   // slot tracking
   input  wire              slot_grant_i,
   input  wire              slot_release_i,
   // =====================================
   // walk cache controls
   output reg               s1_lvl1_walk_cache_off_o,
   output reg               s1_lvl0_walk_cache_off_o
);
   // =====================================
   // storage
   reg  [31:0]       walk_qos_select_reg;
   reg  [31:0]       walk_cache_tuning_reg;
   reg               nonsecure_tuning_access_reg;
   reg               strap_pending_reg;
   wire [SLOT_W-1:0] granted_slot_total;
   wire              req;
   wire              wr;
   wire              ns_block;
   wire [31:0]       wmask;
   reg  [31:0]       rdata;

   // =====================================
   // byte-lane mask
   function [31:0] lanes;
      input [3:0] s;
      begin
         lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [31:0] m;
      begin
         merge = (old & ~m) | (nw & m);
      end
   endfunction

   assign req   = cyc_i && stb_i && !ack_o;
   assign wr    = req && we_i;
   assign wmask = lanes(sel_i);
   assign ns_block = nonsecure_i && !nonsecure_tuning_access_reg;

   // =====================================
   // wishbone handshake, one wait state
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req;
         dat_o <= req ? rdata : 32'h0000_0000;
      end
   end

   // =====================================
   // read decode
   always @* begin
      rdata = 32'h0000_0000;
      case (adr_i)
         `TUTR_TUNING_OFF: begin
            if (!ns_block) rdata = walk_cache_tuning_reg;
         end
         `TUTR_QOS_OFF: begin
            if (!ns_block) rdata = walk_qos_select_reg;
         end
         `TUTR_CFG_OFF: begin
            if (!ns_block) rdata[`TUTR_SLOT_LSB +: SLOT_W] = SHARED_SLOT_PARAM;
         end
         `TUTR_STATUS_OFF: begin
            if (!ns_block) rdata[`TUTR_SLOT_LSB +: SLOT_W] = granted_slot_total;
         end
         `TUTR_SECCTL_OFF: begin
            // secure-only register: nonsecure reads as zero
            if (!nonsecure_i) rdata[`TUTR_NSACC_BIT] = nonsecure_tuning_access_reg;
         end
         default: rdata = 32'h0000_0000;
      endcase
   end

   // =====================================
   // register writes
   always @(posedge clk_i) begin
      if (rst_i) begin
         walk_qos_select_reg         <= `TUTR_QOS_RST;
         walk_cache_tuning_reg       <= `TUTR_TUNING_RST;
         nonsecure_tuning_access_reg <= 1'b0;
         strap_pending_reg           <= 1'b1;
      end else begin
         if (strap_pending_reg) begin
            nonsecure_tuning_access_reg <= sec_override_i;
            strap_pending_reg           <= 1'b0;
         end else if (wr && adr_i == `TUTR_SECCTL_OFF && !nonsecure_i && sel_i[0]) begin
            nonsecure_tuning_access_reg <= dat_i[`TUTR_NSACC_BIT];
         end
         if (wr && adr_i == `TUTR_QOS_OFF && !ns_block
             && !translation_enable_ns_i && !translation_enable_s_i) begin
            walk_qos_select_reg <= merge(walk_qos_select_reg, dat_i,
                                         wmask & `TUTR_QOS_MASK);
         end
         // low aux bits not stored, software keeps them zero anyway
         if (wr && adr_i == `TUTR_TUNING_OFF && !ns_block) begin
            walk_cache_tuning_reg <= merge(walk_cache_tuning_reg, dat_i,
                                           wmask & `TUTR_TUNING_MASK);
         end
      end
   end

   // =====================================
   // walk cache control outputs
   always @(posedge clk_i) begin
      if (rst_i) begin
         s1_lvl1_walk_cache_off_o <= 1'b0;
         s1_lvl0_walk_cache_off_o <= 1'b0;
      end else begin
         s1_lvl1_walk_cache_off_o <= walk_cache_tuning_reg[`TUTR_WC_L1_BIT];
         s1_lvl0_walk_cache_off_o <= walk_cache_tuning_reg[`TUTR_WC_L0_BIT];
      end
   end

   // =====================================
   // submodules
   // per-type priority, walks picked by node priority level
   tutr_qos_sel u_qos (
      .clk_i                 (clk_i),
      .rst_i                 (rst_i),
      .qos_reg_i             (walk_qos_select_reg),
      .txn_type_i            (txn_type_i),
      .node_priority_level_i (node_priority_level_i),
      .axqos_o               (walk_master_port_qos_o)
   );

   tutr_slot_cnt #(
      .W (SLOT_W)
   ) u_slots (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .slot_grant_i   (slot_grant_i),
      .slot_release_i (slot_release_i),
      .count_o        (granted_slot_total)
   );
endmodule // tutr_regs

// ### tutr_defs.vh
// register map, field positions and reset values of the translation tuning registers
`ifndef TUTR_DEFS_VH
`define TUTR_DEFS_VH
// =====================================
// offsets (byte addresses)
`define TUTR_TUNING_OFF       20'h08e00
`define TUTR_QOS_OFF          20'h08e04
`define TUTR_CFG_OFF          20'h08e08
`define TUTR_STATUS_OFF       20'h08e10
`define TUTR_SECCTL_OFF       20'h08e18
// =====================================
// fields
`define TUTR_WC_L1_BIT        9
`define TUTR_WC_L0_BIT        8
`define TUTR_TUNING_MASK      32'h0000_0300
`define TUTR_QOS_MASK         32'h0fff_ffff
`define TUTR_SYNC_LSB         24
`define TUTR_IRQ_LSB          20
`define TUTR_QUEUE_LSB        16
`define TUTR_SLOT_LSB         4
`define TUTR_NSACC_BIT        0
// =====================================
// reset values
`define TUTR_QOS_RST          32'h0000_0000
`define TUTR_TUNING_RST       32'h0000_0000
// =====================================
// transaction types
`define TUTR_TT_WALK          2'h0
`define TUTR_TT_QUEUE         2'h1
`define TUTR_TT_IRQ           2'h2
`define TUTR_TT_SYNC          2'h3
`endif

// ### tutr_qos_sel.v
// per-transaction priority selection for the walk master port
module tutr_qos_sel (
   // =====================================
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // =====================================
   // setting and request
   input  wire [31:0] qos_reg_i,
   input  wire [1:0]  txn_type_i,
   input  wire [1:0]  node_priority_level_i,
   // =====================================
   // result
   output reg  [3:0]  axqos_o
);
`include "tutr_defs.vh"
   // =====================================
   // nibble pick
   function [3:0] nib;
      input [31:0] v;
      input [2:0]  idx;
      begin
         nib = v[idx*4 +: 4];
      end
   endfunction

   // walk priority picked by node priority level; other types use their own field
   always @(posedge clk_i) begin
      if (rst_i) begin
         axqos_o <= 4'h0;
      end else begin
         case (txn_type_i)
            `TUTR_TT_WALK:  axqos_o <= nib(qos_reg_i, {1'b0, node_priority_level_i});
            `TUTR_TT_QUEUE: axqos_o <= qos_reg_i[`TUTR_QUEUE_LSB +: 4];
            `TUTR_TT_IRQ:   axqos_o <= qos_reg_i[`TUTR_IRQ_LSB +: 4];
            default:        axqos_o <= qos_reg_i[`TUTR_SYNC_LSB +: 4];
         endcase
      end
   end
endmodule // tutr_qos_sel

// ### tutr_slot_cnt.v
// granted translation slot counter
module tutr_slot_cnt #(
   parameter W = 12
) (
   // =====================================
   // clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // =====================================
   // grant events
   input  wire         slot_grant_i,
   input  wire         slot_release_i,
   // =====================================
   // count
   output reg  [W-1:0] count_o
);
   // saturate both ways so a stray release cannot wrap
   always @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= {W{1'b0}};
      end else if (slot_grant_i && !slot_release_i && count_o != {W{1'b1}}) begin
         count_o <= count_o + 1'b1;
      end else if (slot_release_i && !slot_grant_i && count_o != {W{1'b0}}) begin
         count_o <= count_o - 1'b1;
      end
   end
endmodule // tutr_slot_cnt

// ### tutr_props.sv
// assertion checker for the translation tuning register bank ports
`include "tutr_defs.vh"
module tutr_props #(
   parameter SLOT_W            = 12,
   parameter SHARED_SLOT_PARAM = 12'h100
) (
   input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i, nonsecure_i, ack_o,
   input wire logic [19:0] adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i, dat_o,
   input wire logic        sec_override_i, translation_enable_ns_i, translation_enable_s_i,
   input wire logic [1:0]  txn_type_i, node_priority_level_i,
   input wire logic [3:0]  walk_master_port_qos_o,
   input wire logic        slot_grant_i, slot_release_i,
   input wire logic        s1_lvl1_walk_cache_off_o, s1_lvl0_walk_cache_off_o
);
   // ====================================
   // properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // secure only, so the access bit cannot hide the write
   wire tun_wr = cyc_i && stb_i && we_i && !nonsecure_i && adr_i == `TUTR_TUNING_OFF;
   AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered next cycle");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   AST_IDLE_DATA: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   AST_RSVD_ZERO: assert property (ack_o |-> dat_o[31:28] == 4'h0)
      else $error("reserved top bits not zero");
   AST_CFG_VALUE: assert property (
      ack_o && !we_i && !nonsecure_i && adr_i == `TUTR_CFG_OFF
      |-> dat_o == (32'(SHARED_SLOT_PARAM) << 4))
      else $error("slot config value wrong");
   AST_L1_FOLLOW: assert property (
      ack_o && tun_wr && sel_i[1] |=> s1_lvl1_walk_cache_off_o == $past(dat_i[9]))
      else $error("level one cache control wrong");
   AST_L0_FOLLOW: assert property (
      ack_o && tun_wr && sel_i[1] |=> s1_lvl0_walk_cache_off_o == $past(dat_i[8]))
      else $error("level zero cache control wrong");
   AST_QOS_CAUSE: assert property (
      $changed(walk_master_port_qos_o)
      |-> $past(txn_type_i) != $past(txn_type_i, 2) || $past(cyc_i && stb_i && we_i, 2)
      || $past(node_priority_level_i) != $past(node_priority_level_i, 2))
      else $error("priority changed without cause");
   AST_RST_CLEAR: assert property (
      $fell(rst_i) |-> walk_master_port_qos_o == 4'h0
      && !s1_lvl1_walk_cache_off_o && !s1_lvl0_walk_cache_off_o && !ack_o)
      else $error("outputs not cleared by reset");
endmodule // tutr_props
bind tutr_regs tutr_props #(.SLOT_W(SLOT_W), .SHARED_SLOT_PARAM(SHARED_SLOT_PARAM)) i_tutr_props (.*);

// ### translation_unit_tuning_regs_bench.sv
// self-checking bench for the translation tuning register bank
`include "tutr_defs.vh"
module translation_unit_tuning_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ====================================
   // stimulus and observed signals
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, nonsecure_i = 0;
   logic [19:0] adr_i = 20'h0;
   logic [3:0]  sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic        sec_override_i = 1, translation_enable_ns_i = 0, translation_enable_s_i = 0;
   logic [1:0]  txn_type_i = 2'h0, node_priority_level_i = 2'h0;
   logic [3:0]  walk_master_port_qos_o;
   logic        slot_grant_i = 0, slot_release_i = 0, ack_o;
   logic        s1_lvl1_walk_cache_off_o, s1_lvl0_walk_cache_off_o;
   int          fails = 0, n_checks = 0;
   // rows: type, level, expected priority; non-walk rows use levels 3, 3, 2 and 0 on purpose
   logic [7:0]  rows [8] = '{8'h01, 8'h12, 8'h23, 8'h34, 8'h75, 8'hb6, 8'he7, 8'h45};
   always #4 clk_i = ~clk_i;
   tutr_regs i_tutr_regs (.*);
   // ====================================
   // tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // waits for ack as long as it takes; only the watchdog ends a hang
   task wb(input logic w, input logic [19:0] a, input logic [31:0] d, input logic ns);
      {cyc_i, stb_i, we_i, nonsecure_i} <= {2'b11, w, ns};
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      {cyc_i, stb_i} <= 2'b00;
      @(posedge clk_i);
   endtask
   task rdc(input logic [19:0] a, input logic ns, input logic [31:0] e);
      wb(1'b0, a, 32'h0, ns);
      chk(rd, e);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ====================================
   // sequence
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 0;
      repeat (2) @(posedge clk_i);
      rdc(`TUTR_QOS_OFF, 0, 32'h0);
      rdc(`TUTR_STATUS_OFF, 0, 32'h0);
      rdc(`TUTR_CFG_OFF, 1, 32'h0000_1000);
      rdc(`TUTR_SECCTL_OFF, 0, 32'h1);
      wb(1, `TUTR_QOS_OFF, 32'hf765_4321, 0);
      rdc(`TUTR_QOS_OFF, 0, 32'h0765_4321);
      foreach (rows[i]) begin
         {txn_type_i, node_priority_level_i} <= rows[i][7:4];
         repeat (2) @(posedge clk_i);
         chk(32'(walk_master_port_qos_o), 32'(rows[i][3:0]));
      end
      $display("test table done");
      // low aux bits always written as zero
      for (int i = 0; i < 4; i++) begin
         wb(1, `TUTR_TUNING_OFF, 32'(i) << 8, 0);
         repeat (2) @(posedge clk_i);
         chk(32'({s1_lvl1_walk_cache_off_o, s1_lvl0_walk_cache_off_o}), 32'(i));
      end
      // either enable alone must block the write
      // qos left unchanged while enables are up, so no invalidate owed
      for (int i = 1; i < 4; i++) begin
         {translation_enable_s_i, translation_enable_ns_i} <= 2'(i);
         wb(1, `TUTR_QOS_OFF, 32'h0, 0);
         rdc(`TUTR_QOS_OFF, 0, 32'h0765_4321);
      end
      {translation_enable_s_i, translation_enable_ns_i} <= 2'b00;
      for (int i = 0; i < 5; i++) begin
         {slot_grant_i, slot_release_i} <= (i < 3) ? 2'b10 : ((i == 3) ? 2'b11 : 2'b01);
         @(posedge clk_i);
      end
      {slot_grant_i, slot_release_i} <= 2'b00;
      rdc(`TUTR_STATUS_OFF, 1, 32'h20);
      $display("test tuning, enables and slots done");
      wb(1, `TUTR_SECCTL_OFF, 32'h0, 0);
      rdc(`TUTR_QOS_OFF, 1, 32'h0);
      rdc(`TUTR_CFG_OFF, 1, 32'h0);
      rdc(`TUTR_STATUS_OFF, 1, 32'h0);
      wb(1, `TUTR_QOS_OFF, 32'h0, 1);
      rdc(`TUTR_QOS_OFF, 0, 32'h0765_4321);
      wb(1, 20'h08e40, 32'hffff_ffff, 0);
      rdc(20'h08e40, 0, 32'h0);
      // single byte lane only touches the low byte
      sel_i <= 4'h1;
      wb(1, `TUTR_QOS_OFF, 32'hffff_ffaa, 0);
      sel_i <= 4'hf;
      rdc(`TUTR_QOS_OFF, 0, 32'h0765_43aa);
      $display("test gating done");
      // mid-run reset with the override strap low
      rst_i <= 1;
      sec_override_i <= 0;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      repeat (2) @(posedge clk_i);
      chk(32'(walk_master_port_qos_o), 32'h0);
      chk(32'({s1_lvl1_walk_cache_off_o, s1_lvl0_walk_cache_off_o}), 32'h0);
      rdc(`TUTR_SECCTL_OFF, 0, 32'h0);
      rdc(`TUTR_QOS_OFF, 0, 32'h0);
      rdc(`TUTR_CFG_OFF, 1, 32'h0);
      $display("test reset done");
      end_of_test;
   end
   // the whole run needs well under a thousand cycles
   initial begin
      #20000;
      fails++;
      end_of_test;
   end
endmodule // translation_unit_tuning_regs_bench
